// ### common/sag_pkg.sv
package sag_pkg;
  // Address widths
  localparam int OFFSET_W = 16;
  localparam int PHYS_W = 20;
  localparam int SEG_SHIFT = 4;
  // Reset values
  localparam logic [15:0] CODE_SEG_RST = 16'hFFFF;
  localparam logic [15:0] DATA_SEG_RST = 16'h0000;
  localparam logic [15:0] IP_RST = 16'h0000;
  localparam logic [15:0] STACK_RST = 16'h0000;
  localparam logic [15:0] INDEX_RST = 16'h0000;
  // Stack and string steps
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  // Reserved regions
  localparam logic [19:0] IVT_LAST = 20'h003FF;
  localparam logic [19:0] RESET_CODE_FIRST = 20'hFFFF0;
  localparam logic [15:0] COPROC_IO_FIRST = 16'h00F8;
  localparam logic [15:0] COPROC_IO_LAST = 16'h00FF;
  // Register bus map
  localparam logic [7:0] CODE_SEG_OFS = 8'h00;
  localparam logic [7:0] DATA_SEG_OFS = 8'h04;
  localparam logic [7:0] STACK_SEG_OFS = 8'h08;
  localparam logic [7:0] EXTRA_SEG_OFS = 8'h0C;
  localparam logic [7:0] IP_OFS = 8'h10;
  localparam logic [7:0] SP_OFS = 8'h14;
  localparam logic [7:0] SRC_IDX_OFS = 8'h18;
  localparam logic [7:0] DST_IDX_OFS = 8'h1C;
  localparam logic [7:0] BASE_PTR_OFS = 8'h20;
  localparam logic [7:0] CTRL_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h28;
  localparam logic [7:0] LAST_ADDR_OFS = 8'h2C;
  localparam int CTRL_DIR_BIT = 0;
  localparam int STAT_IVT_BIT = 0;
  localparam int STAT_IO_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  // Segment selection
  typedef enum logic [1:0] {SEG_EXTRA = 2'b00, SEG_CODE = 2'b01, SEG_STACK = 2'b10, SEG_DATA = 2'b11} sag_seg_e;
  // Reference kinds
  typedef enum logic [2:0] {
    REF_FETCH = 3'd0, REF_STACK = 3'd1, REF_VAR = 3'd2, REF_STR_SRC = 3'd3,
    REF_STR_DST = 3'd4, REF_BASE_PTR = 3'd5, REF_IO = 3'd6
  } sag_ref_e;
  // Operation kinds
  typedef enum logic [2:0] {
    OP_NONE = 3'd0, OP_FETCH = 3'd1, OP_PUSH = 3'd2, OP_POP = 3'd3,
    OP_STRING = 3'd4, OP_ACCESS = 3'd5, OP_IO = 3'd6
  } sag_op_e;
  // Request from execution logic
  typedef struct packed {
    logic valid;
    sag_op_e op;
    sag_ref_e kind;
    logic overrideEn;
    sag_seg_e overrideSeg;
    logic [15:0] effectiveOffset;
    logic wordSize;
    logic write;
    logic [15:0] wdata;
  } sag_req_s;
  // Memory / IO bus request
  typedef struct packed {
    logic valid;
    logic isIo;
    logic write;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic wordSize;
  } sag_bus_s;
  // Address-state machine
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_BUS = 2'b01, ST_STEP = 2'b11} sag_state_e;
endpackage : sag_pkg

// ### hdl/sag_seg_select.sv
// Chooses segment and offset for one reference
module sag_seg_select (
  // Reference description
  input wire sag_pkg::sag_ref_e kind,
  input wire logic overrideEn,
  input wire sag_pkg::sag_seg_e overrideSeg,
  // Offset sources
  input wire logic [15:0] instrPointer,
  input wire logic [15:0] stackOffset,
  input wire logic [15:0] effectiveOffset,
  input wire logic [15:0] srcIndex,
  input wire logic [15:0] destIndex,
  // Selection
  output sag_pkg::sag_seg_e seg,
  output logic [15:0] offset
);
  // Default table; override permitted for variable, string source and base pointer only
  always_comb
  begin
    seg = sag_pkg::SEG_DATA;
    offset = effectiveOffset;
    case (kind)
      sag_pkg::REF_FETCH:
      begin
        seg = sag_pkg::SEG_CODE;
        offset = instrPointer;
      end
      sag_pkg::REF_STACK:
      begin
        seg = sag_pkg::SEG_STACK;
        offset = stackOffset;
      end
      sag_pkg::REF_VAR:
      begin
        seg = overrideEn ? overrideSeg : sag_pkg::SEG_DATA;
        offset = effectiveOffset;
      end
      sag_pkg::REF_STR_SRC:
      begin
        seg = overrideEn ? overrideSeg : sag_pkg::SEG_DATA;
        offset = srcIndex;
      end
      sag_pkg::REF_STR_DST:
      begin
        seg = sag_pkg::SEG_EXTRA;
        offset = destIndex;
      end
      sag_pkg::REF_BASE_PTR:
      begin
        seg = overrideEn ? overrideSeg : sag_pkg::SEG_STACK;
        offset = effectiveOffset;
      end
      default:
      begin
        seg = sag_pkg::SEG_DATA;
        offset = effectiveOffset;
      end
    endcase
  end
endmodule : sag_seg_select

// ### hdl/sag_phys_addr.sv
// Base times sixteen plus offset, wrapped
module sag_phys_addr (
  // Logical address
  input wire logic [15:0] segBase,
  input wire logic [15:0] offset,
  // Physical address
  output logic [19:0] physAddr
);
  logic [20:0] sum;

  // Unsigned sum, carry dropped
  always_comb
  begin
    sum = {1'b0, segBase, 4'h0} + {5'h00, offset};
    physAddr = sum[19:0];
  end
endmodule : sag_phys_addr

// ### hdl/sag_top.sv
module sag_top (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Execution-side request
  input wire sag_pkg::sag_req_s req,
  output logic reqDone,
  output logic [15:0] rdata,
  // External bus
  output sag_pkg::sag_bus_s busOut,
  input wire logic busAck,
  input wire logic [15:0] busRdata,
  // Reserved-region hints
  output logic ivtHit,
  output logic coprocIoHit
);
  sag_pkg::sag_state_e state_r;
  sag_pkg::sag_req_s cur_r;
  logic [15:0] codeSeg_r;
  logic [15:0] dataSeg_r;
  logic [15:0] stackSeg_r;
  logic [15:0] extraSeg_r;
  logic [15:0] instrPointer_r;
  logic [15:0] stackPointer_r;
  logic [15:0] srcIndex_r;
  logic [15:0] destIndex_r;
  logic [15:0] basePointer_r;
  logic directionFlag_r;
  logic [19:0] lastAddr_r;
  logic apValid_r;
  logic apWrite_r;
  logic [7:0] apAddr_r;
  logic busAckS1_r;
  logic busAckS2_r;
  logic [15:0] busRdataS1_r;
  logic [15:0] busRdataS2_r;
  logic busAckSeen_r;
  sag_pkg::sag_seg_e selSeg;
  logic [15:0] selOffset;
  logic [15:0] segBase;
  logic [15:0] stackOffset;
  logic [15:0] idxStep;
  logic [19:0] physAddr;
  logic regWr;
  logic ackRise;

  // Push addresses the already decremented pointer
  assign stackOffset = (cur_r.op == sag_pkg::OP_PUSH) ? 16'(stackPointer_r - sag_pkg::STACK_STEP) :
    stackPointer_r;
  assign idxStep = cur_r.wordSize ? sag_pkg::WORD_STEP : sag_pkg::BYTE_STEP;

  sag_seg_select u_sel (
    .kind(cur_r.kind),
    .overrideEn(cur_r.overrideEn),
    .overrideSeg(cur_r.overrideSeg),
    .instrPointer(instrPointer_r),
    .stackOffset(stackOffset),
    .effectiveOffset(cur_r.effectiveOffset),
    .srcIndex(srcIndex_r),
    .destIndex(destIndex_r),
    .seg(selSeg),
    .offset(selOffset)
  );

  // Segment register mux
  always_comb
  begin
    case (selSeg)
      sag_pkg::SEG_CODE: segBase = codeSeg_r;
      sag_pkg::SEG_STACK: segBase = stackSeg_r;
      sag_pkg::SEG_EXTRA: segBase = extraSeg_r;
      default: segBase = dataSeg_r;
    endcase
  end

  sag_phys_addr u_phys (
    .segBase(segBase),
    .offset(selOffset),
    .physAddr(physAddr)
  );

  // External acknowledge synchroniser
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      busAckS1_r <= 1'b0;
      busAckS2_r <= 1'b0;
      busRdataS1_r <= 16'h0000;
      busRdataS2_r <= 16'h0000;
      busAckSeen_r <= 1'b0;
    end
    else
    begin
      busAckS1_r <= busAck;
      busAckS2_r <= busAckS1_r;
      busRdataS1_r <= busRdata;
      busRdataS2_r <= busRdataS1_r;
      busAckSeen_r <= busAckS2_r;
    end
  end
  assign ackRise = busAckS2_r & ~busAckSeen_r;

  // Reference sequencer
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= sag_pkg::ST_IDLE;
      cur_r <= '0;
      busOut <= '0;
      reqDone <= 1'b0;
      rdata <= 16'h0000;
      lastAddr_r <= sag_pkg::RESET_CODE_FIRST;
      ivtHit <= 1'b0;
      coprocIoHit <= 1'b0;
    end
    else
    begin
      reqDone <= 1'b0;
      case (state_r)
        sag_pkg::ST_IDLE:
        begin
          if (req.valid && req.op != sag_pkg::OP_NONE)
          begin
            cur_r <= req;
            state_r <= sag_pkg::ST_BUS;
          end
        end
        sag_pkg::ST_BUS:
        begin
          if (!busOut.valid)
          begin
            busOut.valid <= 1'b1;
            busOut.isIo <= (cur_r.op == sag_pkg::OP_IO);
            if (cur_r.op == sag_pkg::OP_IO)
            begin
              busOut.addr <= {4'h0, cur_r.effectiveOffset};
              coprocIoHit <= (cur_r.effectiveOffset >= sag_pkg::COPROC_IO_FIRST) &&
                (cur_r.effectiveOffset <= sag_pkg::COPROC_IO_LAST);
            end
            else
            begin
              busOut.addr <= physAddr;
              lastAddr_r <= physAddr;
              ivtHit <= (cur_r.op == sag_pkg::OP_FETCH) && (physAddr <= sag_pkg::IVT_LAST);
            end
            // Stack traffic always word sized
            busOut.wordSize <= (cur_r.op == sag_pkg::OP_PUSH || cur_r.op == sag_pkg::OP_POP) ? 1'b1 :
              cur_r.wordSize;
            busOut.write <= (cur_r.op == sag_pkg::OP_PUSH) ||
              ((cur_r.op == sag_pkg::OP_ACCESS || cur_r.op == sag_pkg::OP_STRING || cur_r.op == sag_pkg::OP_IO)
              && cur_r.write);
            busOut.wdata <= cur_r.wdata;
          end
          else if (ackRise)
          begin
            busOut.valid <= 1'b0;
            rdata <= busRdataS2_r;
            state_r <= sag_pkg::ST_STEP;
          end
        end
        sag_pkg::ST_STEP:
        begin
          reqDone <= 1'b1;
          state_r <= sag_pkg::ST_IDLE;
        end
        default: state_r <= sag_pkg::ST_IDLE;
      endcase
    end
  end

  // Pointer and segment updates
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      codeSeg_r <= sag_pkg::CODE_SEG_RST;
      dataSeg_r <= sag_pkg::DATA_SEG_RST;
      stackSeg_r <= sag_pkg::DATA_SEG_RST;
      extraSeg_r <= sag_pkg::DATA_SEG_RST;
      instrPointer_r <= sag_pkg::IP_RST;
      stackPointer_r <= sag_pkg::STACK_RST;
      srcIndex_r <= sag_pkg::INDEX_RST;
      destIndex_r <= sag_pkg::INDEX_RST;
      basePointer_r <= sag_pkg::INDEX_RST;
    end
    else if (state_r == sag_pkg::ST_STEP)
    begin
      case (cur_r.op)
        sag_pkg::OP_FETCH: instrPointer_r <= 16'(instrPointer_r + idxStep);
        // Pointer moves only after the write or read
        sag_pkg::OP_PUSH: stackPointer_r <= 16'(stackPointer_r - sag_pkg::STACK_STEP);
        sag_pkg::OP_POP: stackPointer_r <= 16'(stackPointer_r + sag_pkg::STACK_STEP);
        sag_pkg::OP_STRING:
        begin
          if (cur_r.kind == sag_pkg::REF_STR_SRC)
            srcIndex_r <= directionFlag_r ? 16'(srcIndex_r - idxStep) : 16'(srcIndex_r + idxStep);
          else
            destIndex_r <= directionFlag_r ? 16'(destIndex_r - idxStep) : 16'(destIndex_r + idxStep);
        end
        default: instrPointer_r <= instrPointer_r;
      endcase
    end
    else if (regWr)
    begin
      case (apAddr_r)
        sag_pkg::CODE_SEG_OFS: codeSeg_r <= hwdata[15:0];
        sag_pkg::DATA_SEG_OFS: dataSeg_r <= hwdata[15:0];
        sag_pkg::STACK_SEG_OFS: stackSeg_r <= hwdata[15:0];
        sag_pkg::EXTRA_SEG_OFS: extraSeg_r <= hwdata[15:0];
        sag_pkg::IP_OFS: instrPointer_r <= hwdata[15:0];
        sag_pkg::SP_OFS: stackPointer_r <= hwdata[15:0];
        sag_pkg::SRC_IDX_OFS: srcIndex_r <= hwdata[15:0];
        sag_pkg::DST_IDX_OFS: destIndex_r <= hwdata[15:0];
        sag_pkg::BASE_PTR_OFS: basePointer_r <= hwdata[15:0];
        default: basePointer_r <= basePointer_r;
      endcase
    end
  end

  // Direction control register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      directionFlag_r <= 1'b0;
    else if (regWr && apAddr_r == sag_pkg::CTRL_OFS)
      directionFlag_r <= hwdata[sag_pkg::CTRL_DIR_BIT];
  end

  // Register writes lose to an active step
  assign regWr = apValid_r && apWrite_r && (state_r != sag_pkg::ST_STEP);

  // AHB address phase capture
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      apValid_r <= 1'b0;
      apWrite_r <= 1'b0;
      apAddr_r <= 8'h00;
    end
    else if (hready)
    begin
      apValid_r <= hsel && htrans[1];
      apWrite_r <= hwrite;
      apAddr_r <= haddr[7:0];
    end
  end

  // AHB read data and ready
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      hreadyout <= 1'b1;
      if (hready && hsel && htrans[1] && !hwrite)
      begin
        case (haddr[7:0])
          sag_pkg::CODE_SEG_OFS: hrdata <= {16'h0000, codeSeg_r};
          sag_pkg::DATA_SEG_OFS: hrdata <= {16'h0000, dataSeg_r};
          sag_pkg::STACK_SEG_OFS: hrdata <= {16'h0000, stackSeg_r};
          sag_pkg::EXTRA_SEG_OFS: hrdata <= {16'h0000, extraSeg_r};
          sag_pkg::IP_OFS: hrdata <= {16'h0000, instrPointer_r};
          sag_pkg::SP_OFS: hrdata <= {16'h0000, stackPointer_r};
          sag_pkg::SRC_IDX_OFS: hrdata <= {16'h0000, srcIndex_r};
          sag_pkg::DST_IDX_OFS: hrdata <= {16'h0000, destIndex_r};
          sag_pkg::BASE_PTR_OFS: hrdata <= {16'h0000, basePointer_r};
          sag_pkg::CTRL_OFS: hrdata <= {31'h00000000, directionFlag_r};
          sag_pkg::STATUS_OFS: hrdata <= {29'h00000000, (state_r != sag_pkg::ST_IDLE), coprocIoHit, ivtHit};
          sag_pkg::LAST_ADDR_OFS: hrdata <= {12'h000, lastAddr_r};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule : sag_top

// ### verif/sag_top_asserts.sv
module sag_top_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  // Execution side and external bus
  input wire sag_pkg::sag_req_s req,
  input wire logic reqDone,
  input wire sag_pkg::sag_bus_s busOut,
  input wire logic busAck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_r;
  logic first_r;
  logic take;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Request accepted when idle, or in the cycle the last one completes
  assign take = req.valid && (req.op != sag_pkg::OP_NONE) && (!busy_r || reqDone);
  // Reference in flight
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      busy_r <= 1'b0;
    else
      busy_r <= take | (busy_r & !reqDone);
  // First reference since reset with untouched registers
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      first_r <= 1'b1;
    else if (take || (hsel && htrans[1] && hwrite))
      first_r <= 1'b0;
  a_take_to_bus: assert property (take |-> ##2 busOut.valid)
    else $error("bus request missing after take");
  a_first_fetch: assert property (take && first_r && req.op == sag_pkg::OP_FETCH |-> ##2 busOut.addr == 20'hFFFF0)
    else $error("first fetch not at reset address");
  a_push_word: assert property (take && req.op == sag_pkg::OP_PUSH |-> ##2 busOut.write && busOut.wordSize)
    else $error("push not a word write");
  a_pop_word: assert property (take && req.op == sag_pkg::OP_POP |-> ##2 !busOut.write && busOut.wordSize)
    else $error("pop not a word read");
  a_io_space: assert property (take |-> ##2 busOut.isIo == (req.op == sag_pkg::OP_IO))
    else $error("wrong address space");
  a_valid_holds: assert property (busOut.valid && !busAck |=> busOut.valid)
    else $error("bus request dropped before ack");
  a_addr_stable: assert property (busOut.valid |=> !busOut.valid || $stable(busOut.addr))
    else $error("address moved during request");
  a_ack_release: assert property ($rose(busAck) |-> ##[1:6] !busOut.valid)
    else $error("request not released after ack");
  a_done_pulse: assert property ($fell(busOut.valid) |=> reqDone ##1 !reqDone)
    else $error("completion pulse wrong");
  cover property (take && req.op == sag_pkg::OP_PUSH);
  cover property (take && req.op == sag_pkg::OP_STRING);
  cover property ($rose(busAck));
endmodule : sag_top_asserts

// ### verif/sag_mem_model.sv
module sag_mem_model (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Request and answer pace
  input wire sag_pkg::sag_bus_s busIn,
  input wire logic [3:0] delay,
  // Answer
  output logic busAck,
  output logic [15:0] busRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [20:0]];
  logic [3:0] waitCnt;
  // Answers after the chosen delay, holds ack until the request drops
  always @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      busAck <= 1'b0;
      busRdata <= 16'h5AA5;
      waitCnt <= 4'h0;
    end
    else if (busIn.valid && !busAck && waitCnt < delay)
      waitCnt <= waitCnt + 4'h1;
    else if (busIn.valid && !busAck)
    begin
      busAck <= 1'b1;
      waitCnt <= 4'h0;
      if (busIn.write)
        mem[{busIn.isIo, busIn.addr}] = busIn.wdata; // I/O kept apart
      busRdata <= mem.exists({busIn.isIo, busIn.addr}) ? mem[{busIn.isIo, busIn.addr}] : ~busIn.addr[15:0];
    end
    else if (!busIn.valid && busAck)
    begin
      busAck <= 1'b0;
      busRdata <= ~busRdata; // No stale value once released
    end
endmodule : sag_mem_model

// ### verif/sag_top_tb.sv
module sag_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus and observed signals
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  sag_pkg::sag_req_s req = '0;
  logic reqDone;
  logic [15:0] rdata;
  sag_pkg::sag_bus_s busOut;
  logic busAck;
  logic [15:0] busRdata;
  logic ivtHit;
  logic coprocIoHit;
  logic [3:0] delay = '0;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] seed = 32'd98802;
  logic [31:0] rv;
  logic [15:0] segs [4];
  localparam logic [7:0] RST_OFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h2C, 8'h30};
  localparam logic [19:0] RST_VAL [7] = '{20'h0FFFF, 20'h0, 20'h0, 20'h0, 20'h0, 20'hFFFF0, 20'h0};
  localparam logic [7:0] SEG_OFS [4] = '{8'h0C, 8'h00, 8'h08, 8'h04};

  sag_top u_dut (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .req(req), .reqDone(reqDone), .rdata(rdata), .busOut(busOut), .busAck(busAck), .busRdata(busRdata),
    .ivtHit(ivtHit), .coprocIoHit(coprocIoHit));
  sag_mem_model u_mem (.clock(clock), .nrst(nrst), .busIn(busOut), .delay(delay), .busAck(busAck),
    .busRdata(busRdata));

  // Clock and hang guard
  initial
    forever #12.5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      $display("mismatch run length expected done seen timeout");
      print_verdict();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [19:0] phys(input logic [15:0] b, input logic [15:0] o);
    return {b, 4'h0} + {4'h0, o};
  endfunction : phys

  function automatic sag_pkg::sag_seg_e segOf(input sag_pkg::sag_ref_e k, input logic ov,
      input sag_pkg::sag_seg_e os);
    if (k == sag_pkg::REF_STR_DST)
      return sag_pkg::SEG_EXTRA;
    if (ov)
      return os;
    return (k == sag_pkg::REF_BASE_PTR) ? sag_pkg::SEG_STACK : sag_pkg::SEG_DATA;
  endfunction : segOf

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One single word transfer on the register bus
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : ahb

  // One reference, held until its bus request drops, then waited on until reqDone
  task automatic doReq(input sag_pkg::sag_op_e op, input sag_pkg::sag_ref_e k, input logic ov,
      input sag_pkg::sag_seg_e os, input logic [15:0] ofs, input logic wsz, input logic wr,
      input logic [15:0] wd, input logic [19:0] expAddr);
    @(posedge clock);
    delay <= 4'(xs() % 6);
    req <= '{1'b1, op, k, ov, os, ofs, wsz, wr, wd};
    repeat (40) if (busOut.valid !== 1'b1) @(posedge clock);
    check("address", expAddr, busOut.addr);
    if (wr)
      check("write data", wd, busOut.wdata);
    repeat (40) if (busOut.valid === 1'b1) @(posedge clock);
    req.valid <= 1'b0;
    repeat (40) if (reqDone !== 1'b1) @(posedge clock);
    check("done", 1'b1, reqDone);
  endtask : doReq

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    logic [31:0] t;
    logic [15:0] si;
    logic [15:0] di;
    logic [15:0] ofs;
    logic [15:0] step;
    sag_pkg::sag_ref_e k;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    // Reset values and an unmapped read
    for (int i = 0; i < 7; i++)
    begin
      ahb(1'b0, RST_OFS[i], '0);
      check("reset value", RST_VAL[i], rv[19:0]);
      check("response", 32'h00000000, {31'h00000000, hresp});
    end
    $display("test reset finished");
    // Fetches ignore the override and advance the pointer
    doReq(sag_pkg::OP_FETCH, sag_pkg::REF_FETCH, 1'b1, sag_pkg::SEG_EXTRA, 16'h0, 1'b1, 1'b0, 16'h0, 20'hFFFF0);
    doReq(sag_pkg::OP_FETCH, sag_pkg::REF_FETCH, 1'b0, sag_pkg::SEG_DATA, 16'h0, 1'b0, 1'b0, 16'h0, 20'hFFFF2);
    ahb(1'b0, 8'h10, '0);
    check("instr pointer", 16'h0003, rv[15:0]);
    $display("test fetch finished");
    // Push from an empty stack wraps, then pop restores
    segs[2] = 16'(xs());
    ahb(1'b1, 8'h08, {16'h0, segs[2]});
    t = xs();
    doReq(sag_pkg::OP_PUSH, sag_pkg::REF_STACK, 1'b1, sag_pkg::SEG_DATA, 16'h0, 1'b0, 1'b1, t[15:0],
      phys(segs[2], 16'hFFFE));
    ahb(1'b0, 8'h14, '0);
    check("stack ptr", 16'hFFFE, rv[15:0]);
    doReq(sag_pkg::OP_POP, sag_pkg::REF_STACK, 1'b1, sag_pkg::SEG_CODE, 16'h0, 1'b0, 1'b0, 16'h0,
      phys(segs[2], 16'hFFFE));
    check("pop data", t[15:0], rdata);
    ahb(1'b0, 8'h14, '0);
    check("stack ptr", 16'h0000, rv[15:0]);
    $display("test stack finished");
    // Sum past the top of memory wraps
    ahb(1'b1, 8'h04, 32'h0000FFFF);
    doReq(sag_pkg::OP_ACCESS, sag_pkg::REF_VAR, 1'b0, sag_pkg::SEG_CODE, 16'h0020, 1'b1, 1'b0, 16'h0, 20'h00010);
    ahb(1'b0, 8'h2C, '0);
    check("last address", 32'h00000010, rv);
    $display("test wrap finished");
    // Random references with overrides and string steps
    for (int i = 0; i < 16; i++)
    begin
      for (int s = 0; s < 4; s++)
      begin
        segs[s] = 16'(xs());
        ahb(1'b1, SEG_OFS[s], {16'h0, segs[s]});
      end
      si = 16'(xs());
      di = 16'(xs());
      t = xs();
      ahb(1'b1, 8'h18, {16'h0, si});
      ahb(1'b1, 8'h1C, {16'h0, di});
      ahb(1'b1, 8'h24, {31'h0, t[0]});
      k = (i % 4 == 0) ? sag_pkg::REF_VAR : (i % 4 == 1) ? sag_pkg::REF_STR_SRC :
        (i % 4 == 2) ? sag_pkg::REF_STR_DST : sag_pkg::REF_BASE_PTR;
      ofs = (k == sag_pkg::REF_STR_SRC) ? si : (k == sag_pkg::REF_STR_DST) ? di : t[31:16];
      doReq((i % 4 == 1 || i % 4 == 2) ? sag_pkg::OP_STRING : sag_pkg::OP_ACCESS, k, t[2],
        sag_pkg::sag_seg_e'(t[4:3]), t[31:16], t[1], t[7], t[23:8],
        phys(segs[segOf(k, t[2], sag_pkg::sag_seg_e'(t[4:3]))], ofs));
      step = t[1] ? 16'h0002 : 16'h0001;
      step = t[0] ? -step : step;
      ahb(1'b0, 8'h18, '0);
      check("source index", (k == sag_pkg::REF_STR_SRC) ? 16'(si + step) : si, rv[15:0]);
      ahb(1'b0, 8'h1C, '0);
      check("dest index", (k == sag_pkg::REF_STR_DST) ? 16'(di + step) : di, rv[15:0]);
    end
    $display("test random finished");
    // Reserved regions are flagged
    doReq(sag_pkg::OP_IO, sag_pkg::REF_IO, 1'b0, sag_pkg::SEG_DATA, 16'h00F8 + t[2:0], 1'b1, 1'b0, 16'h0,
      20'h000F8 + t[2:0]);
    check("coproc hit", 1'b1, coprocIoHit);
    doReq(sag_pkg::OP_IO, sag_pkg::REF_IO, 1'b0, sag_pkg::SEG_DATA, 16'h0080, 1'b1, 1'b1, 16'h1234, 20'h00080);
    check("coproc hit", 1'b0, coprocIoHit);
    ahb(1'b1, 8'h00, '0);
    ahb(1'b1, 8'h10, 32'h000003FE);
    doReq(sag_pkg::OP_FETCH, sag_pkg::REF_FETCH, 1'b0, sag_pkg::SEG_DATA, 16'h0, 1'b1, 1'b0, 16'h0, 20'h003FE);
    check("vector hit", 1'b1, ivtHit);
    doReq(sag_pkg::OP_FETCH, sag_pkg::REF_FETCH, 1'b0, sag_pkg::SEG_DATA, 16'h0, 1'b1, 1'b0, 16'h0, 20'h00400);
    check("vector hit", 1'b0, ivtHit);
    $display("test reserved finished");
    print_verdict();
  end
endmodule : sag_top_tb

bind sag_top sag_top_asserts u_chk (.clock(clock), .nrst(nrst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .req(req), .reqDone(reqDone), .busOut(busOut), .busAck(busAck));
